// ### cac_pkg.sv
// shared constants and state types for the charge converter control pair
// assumes one 10 MHz clock (hclk) and an active-low asynchronous reset
package cac_pkg;

    // ==========================================================
    // configuration word layout, shifted in msb first
    localparam int CFG_BITS  = 12;
    localparam int ACQ_POS   = 10;
    localparam int OS_POS    = 6;
    localparam int LCNT_POS  = 2;
    localparam int RANGE_POS = 1;
    localparam int FMT_POS   = 0;
    localparam logic [CFG_BITS-1:0] CFG_RST = 12'h000;

    localparam logic [1:0] ACQ_NO_CDS = 2'h0;
    localparam logic [1:0] ACQ_K1     = 2'h1;
    localparam logic [1:0] ACQ_K16    = 2'h2;
    localparam logic [1:0] ACQ_K32    = 2'h3;
    localparam logic [4:0] ACQ_CLKS_K16 = 5'h0F;
    localparam logic [4:0] ACQ_CLKS_K32 = 5'h1F;
    localparam logic [3:0] EXP_MAX      = 4'h8;

    // ==========================================================
    // data path widths and straight binary zero codes
    localparam int SAMPLE_W = 20;
    localparam int RESULT_W = 21;
    localparam int ACC_W    = 40;
    localparam logic [RESULT_W-1:0] SB_UNI_ZERO = 21'h001000;
    localparam logic [RESULT_W-1:0] SB_BIP_ZERO = 21'h080000;

    // ==========================================================
    // controller registers (AHB-Lite word offsets)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CFG    = 8'h04;
    localparam logic [7:0] REG_PERIOD = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int CTRL_SETUP_BIT = 0;
    localparam int CTRL_STOP_BIT  = 1;
    localparam int STAT_BUSY_BIT  = 8;
    localparam logic [15:0] PERIOD_RST     = 16'h0400;
    localparam logic [1:0]  END_MIN_CYCLES = 2'h2;

    // ==========================================================
    typedef enum logic [6:0] {
        D_CFG  = 7'b0000001,
        D_WAIT = 7'b0000010,
        D_RST  = 7'b0000100,
        D_ACQ  = 7'b0001000,
        D_INIT = 7'b0010000,
        D_MEAS = 7'b0100000,
        D_FIN  = 7'b1000000
    } cac_dev_state_t;

    typedef enum logic [4:0] {
        H_HOLD  = 5'b00001,
        H_SHIFT = 5'b00010,
        H_ARM   = 5'b00100,
        H_RUN   = 5'b01000,
        H_END   = 5'b10000
    } cac_host_state_t;

endpackage : cac_pkg

// ### cac_link_if.sv
// link between the setup/integration controller and the converter control
// assumes both ends share hclk; all signals change just after a rising edge
`timescale 1ns/1ps
interface cac_link_if (
    input wire logic hclk
);
    logic reset_sys_n;
    logic integ_ctrl_n;
    logic cfg_strobe;
    logic cfg_data;
    logic point_busy;

    modport dev_mp (
        input  reset_sys_n,
        input  integ_ctrl_n,
        input  cfg_strobe,
        input  cfg_data,
        output point_busy
    );

    modport host_mp (
        output reset_sys_n,
        output integ_ctrl_n,
        output cfg_strobe,
        output cfg_data,
        input  point_busy
    );
endinterface : cac_link_if

// ### cac_dev.sv
// converter control end: setup capture, acquisition phase, double sampling
// and averaging of integrations into one conversion result
// assumes link inputs synchronous to hclk and one raw sample per clock
`timescale 1ns/1ps

module cac_dev (
    input  wire logic                           hclk,
    input  wire logic                           hresetn,
    cac_link_if.dev_mp                          link,
    input  wire logic [cac_pkg::SAMPLE_W-1:0]   sample_in,
    output logic      [cac_pkg::RESULT_W-1:0]   result,
    output logic                                result_valid,
    output logic      [cac_pkg::CFG_BITS-1:0]   cfg_word,
    output logic                                cds_enabled,
    output logic                                acq_active
);
    import cac_pkg::*;

    // ==========================================================
    // decoding helpers
    // power-of-two exponent
    function automatic logic [3:0] pow_exp(input logic [3:0] code);
        pow_exp = code[3] ? EXP_MAX : {1'b0, code[2:0]};
    endfunction : pow_exp

    function automatic logic [8:0] pow_count(input logic [3:0] code);
        pow_count = 9'h001 << pow_exp(code);
    endfunction : pow_count

    // ==========================================================
    // state
    cac_dev_state_t            state,      next_state;
    logic [CFG_BITS-1:0]       shift_reg,  next_shift_reg;
    logic [3:0]                shift_cnt,  next_shift_cnt;
    logic [CFG_BITS-1:0]       next_cfg_word;
    logic [4:0]                acq_cnt,    next_acq_cnt;
    logic [8:0]                smp_cnt,    next_smp_cnt;
    logic [8:0]                int_cnt,    next_int_cnt;
    logic signed [ACC_W-1:0]   init_acc,   next_init_acc;
    logic signed [ACC_W-1:0]   fin_acc,    next_fin_acc;
    logic [RESULT_W-1:0]       next_result;
    logic                      next_result_valid;

    logic [1:0]                acq_code;
    logic [3:0]                os_code;
    logic [3:0]                l_code;
    logic                      bipolar;
    logic                      twos_fmt;
    logic [4:0]                acq_clks;
    logic [8:0]                m_count;
    logic [8:0]                l_count;
    logic signed [ACC_W-1:0]   sample_ext;
    logic signed [ACC_W-1:0]   total;
    logic signed [ACC_W-1:0]   avg;
    logic [4:0]                avg_shift;

    assign acq_code = cfg_word[ACQ_POS+1:ACQ_POS];
    assign os_code  = cfg_word[OS_POS+3:OS_POS];
    assign l_code   = cfg_word[LCNT_POS+3:LCNT_POS];
    assign bipolar  = cfg_word[RANGE_POS];
    assign twos_fmt = cfg_word[FMT_POS];
    assign l_count  = pow_count(l_code);
    assign m_count  = pow_count(os_code);
    assign cds_enabled = (acq_code != ACQ_NO_CDS);
    assign sample_ext  = $signed({{(ACC_W-SAMPLE_W){1'b0}}, sample_in});
    assign avg_shift   = {1'b0, pow_exp(os_code)} + {1'b0, pow_exp(l_code)};

    // acquisition clocks after the reset clock
    always_comb begin
        case (acq_code)
            ACQ_K16: acq_clks = ACQ_CLKS_K16;
            ACQ_K32: acq_clks = ACQ_CLKS_K32;
            default: acq_clks = 5'h00;
        endcase
    end

    assign acq_active      = (state == D_RST) || (state == D_ACQ);
    assign link.point_busy = acq_active || (state == D_INIT) || (state == D_FIN);

    // ==========================================================
    // next-state logic
    always_comb begin
        next_state        = state;
        next_shift_reg    = shift_reg;
        next_shift_cnt    = shift_cnt;
        next_cfg_word     = cfg_word;
        next_acq_cnt      = acq_cnt;
        next_smp_cnt      = smp_cnt;
        next_int_cnt      = int_cnt;
        next_init_acc     = init_acc;
        next_fin_acc      = fin_acc;
        next_result       = result;
        next_result_valid = 1'b0;
        total             = fin_acc + sample_ext - init_acc;
        avg               = total >>> avg_shift;

        if (!link.reset_sys_n) begin
            // setup load while held in reset
            next_state    = D_CFG;
            next_int_cnt  = 9'h000;
            next_init_acc = '0;
            next_fin_acc  = '0;
            if (link.cfg_strobe) begin
                next_shift_reg = {shift_reg[CFG_BITS-2:0], link.cfg_data};
                if (shift_cnt == 4'(CFG_BITS - 1)) begin
                    // commit on the twelfth bit only
                    next_cfg_word  = {shift_reg[CFG_BITS-2:0], link.cfg_data};
                    next_shift_cnt = 4'h0;
                end else begin
                    next_shift_cnt = shift_cnt + 4'h1;
                end
            end
        end else begin
            case (state)
                D_CFG: begin
                    // a partial word is dropped on release
                    next_shift_cnt = 4'h0;
                    next_state     = D_WAIT;
                end
                D_WAIT: begin
                    // start on release of integration control
                    if (link.integ_ctrl_n) begin
                        next_state = D_RST;
                    end
                end
                D_RST: begin
                    next_acq_cnt = acq_clks;
                    next_smp_cnt = 9'h000;
                    if (acq_clks != 5'h00) begin
                        next_state = D_ACQ;
                    end else if (cds_enabled) begin
                        next_state = D_INIT;
                    end else begin
                        next_state = D_MEAS;
                    end
                end
                D_ACQ: begin
                    // then 15 or 31 acquisition clocks
                    next_acq_cnt = acq_cnt - 5'h01;
                    if (acq_cnt == 5'h01) begin
                        next_state = cds_enabled ? D_INIT : D_MEAS;
                    end
                end
                D_INIT: begin
                    next_init_acc = init_acc + sample_ext;
                    next_smp_cnt  = smp_cnt + 9'h001;
                    if (smp_cnt == m_count - 9'h001) begin
                        next_smp_cnt = 9'h000;
                        next_state   = D_MEAS;
                    end
                end
                D_MEAS: begin
                    if (!link.integ_ctrl_n) begin
                        next_smp_cnt = 9'h000;
                        next_state   = D_FIN;
                    end
                end
                D_FIN: begin
                    next_fin_acc = fin_acc + sample_ext;
                    next_smp_cnt = smp_cnt + 9'h001;
                    if (smp_cnt == m_count - 9'h001) begin
                        next_state   = D_WAIT;
                        next_int_cnt = int_cnt + 9'h001;
                        if (int_cnt == l_count - 9'h001) begin
                            // subtract the initial sum at the end
                            // bipolar straight binary with cds may wrap
                            if (twos_fmt) begin
                                next_result = avg[RESULT_W-1:0];
                            end else if (bipolar) begin
                                next_result = {1'b0, 20'(avg[RESULT_W-2:0] + SB_BIP_ZERO[RESULT_W-2:0])};
                            end else begin
                                next_result = {1'b0, 20'(avg[RESULT_W-2:0] + SB_UNI_ZERO[RESULT_W-2:0])};
                            end
                            next_result_valid = 1'b1;
                            next_int_cnt      = 9'h000;
                            next_init_acc     = '0;
                            next_fin_acc      = '0;
                        end
                    end
                end
                default: begin
                    next_state = D_CFG;
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state        <= D_CFG;
            shift_reg    <= CFG_RST;
            shift_cnt    <= 4'h0;
            cfg_word     <= CFG_RST;
            acq_cnt      <= 5'h00;
            smp_cnt      <= 9'h000;
            int_cnt      <= 9'h000;
            init_acc     <= '0;
            fin_acc      <= '0;
            result       <= '0;
            result_valid <= 1'b0;
        end else begin
            state        <= next_state;
            shift_reg    <= next_shift_reg;
            shift_cnt    <= next_shift_cnt;
            cfg_word     <= next_cfg_word;
            acq_cnt      <= next_acq_cnt;
            smp_cnt      <= next_smp_cnt;
            int_cnt      <= next_int_cnt;
            init_acc     <= next_init_acc;
            fin_acc      <= next_fin_acc;
            result       <= next_result;
            result_valid <= next_result_valid;
        end
    end

endmodule : cac_dev

// ### cac_host.sv
// host end: AHB-Lite register slave that sequences setup load, start
// and the integration control of the converter control end
// assumes a single zero-wait AHB-Lite master on hclk
`timescale 1ns/1ps
module cac_host (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic      [31:0]    hrdata,
    output logic                hreadyout,
    output logic                hresp,
    cac_link_if.host_mp         link
);
    import cac_pkg::*;

    cac_host_state_t        state,      next_state;
    logic [CFG_BITS-1:0]    cfg_reg,    next_cfg_reg;
    logic [15:0]            period,     next_period;
    logic [15:0]            cnt,        next_cnt;
    logic [3:0]             bit_idx,    next_bit_idx;
    logic                   wr_pend,    next_wr_pend;
    logic [7:0]             wr_addr,    next_wr_addr;
    logic [31:0]            next_hrdata;
    logic                   addr_ok;
    logic                   do_setup;
    logic                   do_stop;

    // ==========================================================
    // bus slave: never stalls, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && htrans[1] && hready && (hsize == 3'h2);
    assign do_setup  = wr_pend && (wr_addr == REG_CTRL) && hwdata[CTRL_SETUP_BIT];
    assign do_stop   = wr_pend && (wr_addr == REG_CTRL) && hwdata[CTRL_STOP_BIT];

    always_comb begin
        next_wr_pend = addr_ok && hwrite;
        next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
        next_hrdata  = hrdata;
        next_cfg_reg = cfg_reg;
        next_period  = period;
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                REG_CFG:    next_hrdata = {20'h00000, cfg_reg};
                REG_PERIOD: next_hrdata = {16'h0000, period};
                REG_STATUS: next_hrdata = {23'h000000, link.point_busy, 3'h0, state};
                default:    next_hrdata = 32'h00000000;
            endcase
        end
        if (wr_pend && (wr_addr == REG_CFG)) begin
            next_cfg_reg = hwdata[CFG_BITS-1:0];
        end
        if (wr_pend && (wr_addr == REG_PERIOD)) begin
            next_period = hwdata[15:0];
        end
    end

    // ==========================================================
    // link sequencer
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_bit_idx = bit_idx;
        case (state)
            H_HOLD: begin
                if (do_setup) begin
                    next_bit_idx = 4'(CFG_BITS - 1);
                    next_state   = H_SHIFT;
                end
            end
            H_SHIFT: begin
                // one bit per clock, msb first
                // word sent as stored: acq field first
                if (bit_idx == 4'h0) begin
                    next_state = H_ARM;
                end else begin
                    next_bit_idx = bit_idx - 4'h1;
                end
            end
            H_ARM: begin
                next_cnt   = 16'h0000;
                next_state = H_RUN;
            end
            H_RUN: begin
                next_cnt = cnt + 16'h0001;
                if (cnt == period - 16'h0001) begin
                    next_cnt   = 16'h0000;
                    next_state = H_END;
                end
            end
            H_END: begin
                // hold control until the final point is taken
                if (cnt[1:0] != END_MIN_CYCLES) begin
                    next_cnt = cnt + 16'h0001;
                end else if (!link.point_busy) begin
                    next_cnt   = 16'h0000;
                    next_state = H_RUN;
                end
            end
            default: begin
                next_state = H_HOLD;
            end
        endcase
        if (do_stop) begin
            next_state = H_HOLD;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state             <= H_HOLD;
            cfg_reg           <= CFG_RST;
            period            <= PERIOD_RST;
            cnt               <= 16'h0000;
            bit_idx           <= 4'h0;
            wr_pend           <= 1'b0;
            wr_addr           <= 8'h00;
            hrdata            <= 32'h00000000;
            link.reset_sys_n  <= 1'b0;
            link.integ_ctrl_n <= 1'b0;
            link.cfg_strobe   <= 1'b0;
            link.cfg_data     <= 1'b0;
        end else begin
            state             <= next_state;
            cfg_reg           <= next_cfg_reg;
            period            <= next_period;
            cnt               <= next_cnt;
            bit_idx           <= next_bit_idx;
            wr_pend           <= next_wr_pend;
            wr_addr           <= next_wr_addr;
            hrdata            <= next_hrdata;
            // reset released first, control still low
            link.reset_sys_n  <= (next_state == H_ARM) || (next_state == H_RUN) || (next_state == H_END);
            // control released only after reset release
            link.integ_ctrl_n <= (next_state == H_RUN);
            link.cfg_strobe   <= (next_state == H_SHIFT);
            link.cfg_data     <= (next_state == H_SHIFT) && cfg_reg[next_bit_idx];
        end
    end

endmodule : cac_host

// ### cac_monitor.sv
// link checker for the converter control pair
// assumes it is placed beside the link interface and fed by name
`timescale 1ns/1ps
module cac_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic reset_sys_n,
    input wire logic integ_ctrl_n,
    input wire logic cfg_strobe,
    input wire logic cfg_data,
    input wire logic point_busy
);
    import cac_pkg::*;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // strobe run length, counted so a long run needs no repetition
    logic [3:0] strobe_run, next_strobe_run;

    always_comb begin
        next_strobe_run = cfg_strobe ? strobe_run + 4'h1 : 4'h0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strobe_run <= 4'h0;
        end else begin
            strobe_run <= next_strobe_run;
        end
    end

    // ==========================================================
    // setup load and start sequence
    a_strobe_run_len: assert property ($fell(cfg_strobe) |-> strobe_run == 4'(CFG_BITS))
        else $error("setup strobe run is not twelve cycles");
    a_strobe_run_max: assert property (cfg_strobe |-> strobe_run < 4'(CFG_BITS))
        else $error("setup strobe run longer than twelve cycles");
    a_load_in_reset: assert property (cfg_strobe |-> !reset_sys_n && !integ_ctrl_n)
        else $error("setup bit sent outside reset");
    a_release_order: assert property ($fell(cfg_strobe) |->
        ##[0:2] (reset_sys_n && !integ_ctrl_n) ##1 integ_ctrl_n)
        else $error("release order after load wrong");
    a_start_after_reset: assert property ($rose(integ_ctrl_n) |-> reset_sys_n)
        else $error("integration started in system reset");

    // ==========================================================
    // integration delimiting by the control input
    a_busy_after_start: assert property ($rose(integ_ctrl_n) |=> point_busy)
        else $error("no reset clock after integration start");
    a_end_low_hold: assert property ($fell(integ_ctrl_n) |-> !integ_ctrl_n[*3])
        else $error("integration end shorter than three cycles");
    a_end_until_idle: assert property ($rose(integ_ctrl_n) |-> !$past(point_busy))
        else $error("integration restarted while busy");
    // a stop drops system reset together with the control, so no final point follows
    a_fin_bounded: assert property ($fell(integ_ctrl_n) && reset_sys_n |->
        ##1 point_busy ##[1:300] !point_busy)
        else $error("final point never ended");
    // longest busy stretch is 1 + 31 + 256 clocks
    a_busy_bounded: assert property ($rose(point_busy) |-> ##[1:300] !point_busy)
        else $error("busy stretch too long");

    cover property ($fell(cfg_strobe));
    cover property ($rose(integ_ctrl_n) ##1 point_busy);
    cover property (cfg_strobe && cfg_data);
endmodule : cac_monitor

// ### tb_top.sv
// self-checking bench: AHB-Lite master on the host, random samples into
// the converter end, reference model built from the link activity
`timescale 1ns/1ps
module tb_top;
    import cac_pkg::*;
    logic hclk, hresetn, hsel, hwrite, result_valid, cds_enabled, acq_active, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [SAMPLE_W-1:0] sample_in;
    logic [RESULT_W-1:0] result, e;
    logic [CFG_BITS-1:0] cfg_word, cfg_tab [5];
    int n_fail, tests_run, cyc, acq_n, n_int, ni, nf, n_res, r0, cur_acq, cur_mc, cur_lc, k_tab [4];
    logic cur_rng, cur_fmt;
    longint si, sf, d;

    cac_link_if link (.hclk(hclk));
    cac_host u_cac_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(link));
    cac_dev u_cac_dev (.hclk(hclk), .hresetn(hresetn), .link(link), .sample_in(sample_in),
        .result(result), .result_valid(result_valid), .cfg_word(cfg_word),
        .cds_enabled(cds_enabled), .acq_active(acq_active));
    cac_monitor u_cac_monitor (.hclk(hclk), .hresetn(hresetn), .reset_sys_n(link.reset_sys_n),
        .integ_ctrl_n(link.integ_ctrl_n), .cfg_strobe(link.cfg_strobe), .cfg_data(link.cfg_data),
        .point_busy(link.point_busy));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= 32'(a);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : ahb

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ==========================================================
    // random samples, timeout and reference model
    always @(posedge hclk) begin
        seed = lfsr(seed);
        sample_in <= seed[SAMPLE_W-1:0];
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            report_and_stop();
        end
    end

    always @(posedge hclk) begin
        if (!hresetn || !link.reset_sys_n) begin
            {acq_n, n_int, ni, nf} = '0;
            si = 0;
            sf = 0;
        end else begin
            if (acq_active) acq_n++;
            else if (acq_n != 0) begin
                check("acq_len", 32'(acq_n), 32'(1 + k_tab[cur_acq]));
                acq_n = 0;
                n_int++;
            end
            if (link.point_busy && !acq_active && link.integ_ctrl_n) begin
                si += sample_in;
                ni++;
            end
            if (link.point_busy && !acq_active && !link.integ_ctrl_n) begin
                sf += sample_in;
                nf++;
            end
            if (result_valid) begin
                d = (sf - si) >>> (cur_mc + cur_lc);
                e = cur_fmt ? d[20:0] : {1'b0, d[19:0] + (cur_rng ? SB_BIP_ZERO[19:0] : SB_UNI_ZERO[19:0])};
                check("result", 32'(result), 32'(e));
                check("integrations", 32'(n_int), 32'(1 << cur_lc));
                check("final_pts", 32'(nf), 32'(1 << (cur_mc + cur_lc)));
                check("init_pts", 32'(ni), cur_acq != 0 ? 32'(1 << (cur_mc + cur_lc)) : 32'h0);
                {n_int, ni, nf} = '0;
                si = 0;
                sf = 0;
                n_res++;
            end
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {n_fail, tests_run, cyc, n_res, cur_acq, cur_mc, cur_lc} = '0;
        seed = 32'h00000056;
        k_tab = '{0, 0, 15, 31};
        // straight no cds, K1 bipolar, K16 two integrations, K32 with 256 samples,
        // bipolar straight without cds
        // sixteen-clock entry included
        cfg_tab = '{12'h044, 12'h403, 12'h885, 12'hE01, 12'h006};
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, REG_STATUS, 32'h0, rd);
        check("status", rd, 32'h00000001);
        ahb(1'b0, REG_PERIOD, 32'h0, rd);
        check("period", rd, 32'(PERIOD_RST));
        ahb(1'b0, 8'h10, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        check("hresp", 32'(hresp), 32'h0);
        ahb(1'b1, REG_PERIOD, 32'h00000180, rd);
        for (int i = 0; i < 5; i++) begin
            ahb(1'b1, REG_CTRL, 32'h00000002, rd);
            ahb(1'b1, REG_CFG, 32'(cfg_tab[i]), rd);
            ahb(1'b0, REG_CFG, 32'h0, rd);
            check("cfg_reg", rd, 32'(cfg_tab[i]));
            cur_acq = int'(cfg_tab[i][11:10]);
            cur_mc = cfg_tab[i][9] ? 8 : int'(cfg_tab[i][8:6]);
            cur_lc = cfg_tab[i][5] ? 8 : int'(cfg_tab[i][4:2]);
            cur_rng = cfg_tab[i][1];
            cur_fmt = cfg_tab[i][0];
            ahb(1'b1, REG_CTRL, 32'h00000001, rd);
            repeat (6) @(posedge hclk);
            check("cfg_partial", 32'(cfg_word), i == 0 ? 32'h0 : 32'(cfg_tab[i - 1]));
            r0 = n_res;
            while (n_res == r0) @(posedge hclk);
            check("cfg_word", 32'(cfg_word), 32'(cfg_tab[i]));
            check("cds_on", 32'(cds_enabled), 32'(cur_acq != 0));
        end
        report_and_stop();
    end
endmodule : tb_top
